//--- logic/hbpwm_top.sv
// hbpwm_top: three-pair pwm generator with bridge output steering
// assumes synchronous inputs, one 200 MHz clock, register port master
`timescale 1ns/100ps
`default_nettype none

module hbpwm_top
    import hbpwm_pkg::*;
#(
    parameter int TW = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // register port
    input  wire logic [31:0]  addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         wr,
    input  wire logic         rd,
    output logic      [31:0]  rdata,
    // link pins
    input  wire logic         trip_n,
    input  wire logic         sync_n,
    output hbpwm_out_s        pwm_out,
    output logic              pin_pwm_select,
    output logic              pwm_irq
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0]    control;
    hbpwm_pair_s    shadow [3];
    hbpwm_pair_s    active [3];
    logic [TW-1:0]  timer [3];
    logic [7:0]     presc;
    logic           tick;
    logic           sync_q;
    logic           sync_fall;
    logic           trip_hit;
    logic           clr_hit;
    hbpwm_out_s     wave;
    hbpwm_out_s     next_out;
    logic [2:0]     wrap;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
        return a == o;
    endfunction

    assign trip_hit  = control[BIT_TRIP_EN] && !trip_n;
    assign clr_hit   = wr && hit(addr, OFS_INT_CLEAR);
    assign sync_fall = control[BIT_SYNC_EN] && sync_q && !sync_n;

    // ************************************************************
    // control register and trip
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            control <= CONTROL_RESET;
        end else begin
            if (wr && hit(addr, OFS_CONTROL)) begin
                control <= wdata[15:0] & CONTROL_MASK;
            end
            if (trip_hit) begin
                control[BIT_GLOBAL_EN] <= 1'b0;
            end
        end
    end

    // trip set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (reset) begin
            pwm_irq <= 1'b0;
        end else if (trip_hit) begin
            pwm_irq <= 1'b1;
        end else if (clr_hit) begin
            pwm_irq <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_pwm_select <= 1'b0;
        end else begin
            pin_pwm_select <= 1'b1;
        end
    end

    // ************************************************************
    // compare register file
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                shadow[i] <= '0;
            end
        end else if (wr) begin
            if (hit(addr, OFS_P0_RISE_A)) shadow[0].rise   <= wdata[15:0];
            if (hit(addr, OFS_P0_FALL_A)) shadow[0].fall   <= wdata[15:0];
            if (hit(addr, OFS_P0_FALL_B)) shadow[0].fall2  <= wdata[15:0];
            if (hit(addr, OFS_P0_LENGTH)) shadow[0].length <= wdata[15:0];
            if (hit(addr, OFS_P1_RISE_C)) shadow[1].rise   <= wdata[15:0];
            if (hit(addr, OFS_P1_FALL_C)) shadow[1].fall   <= wdata[15:0];
            if (hit(addr, OFS_P1_FALL_D)) shadow[1].fall2  <= wdata[15:0];
            if (hit(addr, OFS_P1_LENGTH)) shadow[1].length <= wdata[15:0];
            if (hit(addr, OFS_P2_RISE_E)) shadow[2].rise   <= wdata[15:0];
            if (hit(addr, OFS_P2_FALL_E)) shadow[2].fall   <= wdata[15:0];
            if (hit(addr, OFS_P2_LENGTH)) shadow[2].length <= wdata[15:0];
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= '0;
            if (hit(addr, OFS_CONTROL))   rdata[15:0] <= control;
            if (hit(addr, OFS_P0_RISE_A)) rdata[15:0] <= shadow[0].rise;
            if (hit(addr, OFS_P0_FALL_A)) rdata[15:0] <= shadow[0].fall;
            if (hit(addr, OFS_P0_FALL_B)) rdata[15:0] <= shadow[0].fall2;
            if (hit(addr, OFS_P0_LENGTH)) rdata[15:0] <= shadow[0].length;
            if (hit(addr, OFS_P1_RISE_C)) rdata[15:0] <= shadow[1].rise;
            if (hit(addr, OFS_P1_FALL_C)) rdata[15:0] <= shadow[1].fall;
            if (hit(addr, OFS_P1_FALL_D)) rdata[15:0] <= shadow[1].fall2;
            if (hit(addr, OFS_P1_LENGTH)) rdata[15:0] <= shadow[1].length;
            if (hit(addr, OFS_P2_RISE_E)) rdata[15:0] <= shadow[2].rise;
            if (hit(addr, OFS_P2_FALL_E)) rdata[15:0] <= shadow[2].fall;
            if (hit(addr, OFS_P2_LENGTH)) rdata[15:0] <= shadow[2].length;
            if (hit(addr, OFS_STATUS)) begin
                rdata[0] <= pwm_irq;
                rdata[5:1] <= pwm_out;
            end
        end else begin
            rdata <= '0;
        end
    end

    // ************************************************************
    // prescaler and sync
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            presc  <= PRESC_RESET;
            sync_q <= 1'b1;
        end else begin
            sync_q <= sync_n;
            if (sync_fall) begin
                presc <= PRESC_RESET;
            end else begin
                presc <= presc + 8'h01;
            end
        end
    end

    // tick every 2^(code+1) clocks
    always_comb begin
        tick = (presc | ~((8'h02 << control[BIT_PRESC_LO +: 3]) - 8'h01))
               == 8'hff;
    end

    // ************************************************************
    // timers and compare load
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                timer[i]  <= '0;
                active[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sync_fall) begin
                    timer[i] <= '0;
                end else if (tick) begin
                    timer[i] <= wrap[i] ? '0 : timer[i] + 1'b1;
                    if (control[BIT_LOAD] && timer[i] == '0) begin
                        active[i] <= shadow[i];
                    end
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            wrap[i] = timer[i] >= active[i].length[TW-1:0];
        end
    end

    // ************************************************************
    // compare waveforms
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            wave <= '0;
        end else if (tick) begin
            if (timer[0] == active[0].rise)   wave.a <= 1'b1;
            if (timer[0] == active[0].fall)   wave.a <= 1'b0;
            if (timer[0] == active[0].fall2)  wave.b <= 1'b0;
            if (timer[0] == active[0].length) wave.b <= 1'b1;
            if (timer[1] == active[1].rise)   wave.c <= 1'b1;
            if (timer[1] == active[1].fall)   wave.c <= 1'b0;
            if (timer[1] == active[1].fall2)  wave.d <= 1'b0;
            if (timer[1] == active[1].length) wave.d <= 1'b1;
            if (timer[2] == active[2].rise)   wave.e <= 1'b1;
            if (timer[2] == active[2].fall)   wave.e <= 1'b0;
        end
    end

    // ************************************************************
    // output selection
    // ************************************************************
    always_comb begin
        logic hs;
        logic ls;
        hs = wave.a;
        ls = wave.b;
        next_out = wave;
        if (control[BIT_INV_B]) next_out.b = ~wave.b;
        if (control[BIT_INV_D]) next_out.d = ~wave.d;
        if (control[BIT_BRIDGE_MODE]) begin
            if (control[BIT_HS_FORCE]) begin
                next_out.a = 1'b1;
                next_out.b = 1'b0;
                next_out.c = 1'b1;
                next_out.d = 1'b0;
            end else if (!control[BIT_BRIDGE_EN]) begin
                next_out.a = 1'b1;
                next_out.b = 1'b1;
                next_out.c = 1'b1;
                next_out.d = 1'b1;
            end else if (control[BIT_DIR] ^ control[BIT_INVERT_ALL]) begin
                next_out.a = hs;
                next_out.b = ls;
                next_out.c = control[BIT_INVERT_ALL];
                next_out.d = control[BIT_INVERT_ALL];
            end else begin
                next_out.a = control[BIT_INVERT_ALL];
                next_out.b = control[BIT_INVERT_ALL];
                next_out.c = hs;
                next_out.d = ls;
            end
        end else begin
            if (control[BIT_INVERT_ALL]) next_out = ~next_out;
            if (!control[BIT_GLOBAL_EN]) next_out = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= next_out;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_reset_ctrl;
        @(posedge clk) $fell(reset) |-> control == CONTROL_RESET;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("ctrl reset");

    property p_force;
        @(posedge clk) disable iff (reset)
        control[BIT_BRIDGE_MODE] && control[BIT_HS_FORCE]
            ##1 control[BIT_BRIDGE_MODE] && control[BIT_HS_FORCE]
            |=> pwm_out.a && !pwm_out.b && pwm_out.c && !pwm_out.d;
    endproperty
    a_force: assert property (p_force) else $error("force");

    property p_clear;
        @(posedge clk) disable iff (reset)
        clr_hit && !trip_hit |=> !pwm_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("irq clear");

    property p_trip;
        @(posedge clk) disable iff (reset)
        trip_hit |=> pwm_irq && !control[BIT_GLOBAL_EN];
    endproperty
    a_trip: assert property (p_trip) else $error("trip");

    property p_sync;
        @(posedge clk) disable iff (reset)
        sync_fall |=> timer[0] == '0 && presc == PRESC_RESET;
    endproperty
    a_sync: assert property (p_sync) else $error("sync");

    property p_rise_a;
        @(posedge clk) disable iff (reset)
        tick && timer[0] == active[0].rise && timer[0] != active[0].fall
            |=> wave.a;
    endproperty
    a_rise_a: assert property (p_rise_a) else $error("rise a");

    property p_fall_a;
        @(posedge clk) disable iff (reset)
        tick && timer[0] == active[0].fall |=> !wave.a;
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("fall a");

    property p_wrap;
        @(posedge clk) disable iff (reset)
        tick && !sync_fall && wrap[2] |=> timer[2] == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");

    property p_count;
        @(posedge clk) disable iff (reset)
        tick && !sync_fall && !wrap[0] |=> timer[0] == $past(timer[0]) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("count");

    property p_all_high;
        @(posedge clk) disable iff (reset)
        control[BIT_BRIDGE_MODE] && !control[BIT_HS_FORCE]
            && !control[BIT_BRIDGE_EN]
            |=> pwm_out.a && pwm_out.b && pwm_out.c && pwm_out.d;
    endproperty
    a_all_high: assert property (p_all_high) else $error("all high");

    property p_pin_sel;
        @(posedge clk) !reset |=> pin_pwm_select;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin select");

    property p_rise_e;
        @(posedge clk) disable iff (reset)
        tick && timer[2] == active[2].rise && timer[2] != active[2].fall
            |=> wave.e;
    endproperty
    a_rise_e: assert property (p_rise_e) else $error("rise e");

endmodule

`default_nettype wire

//--- logic/hbpwm_pkg.sv
// hbpwm_pkg: constants and carrier types of the bridge pwm compare unit
// assumes a plain address/strobe register port, 32-bit byte addresses
`default_nettype none
package hbpwm_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [31:0] OFS_CONTROL     = 32'hffff0f80;
    localparam logic [31:0] OFS_P0_RISE_A   = 32'hffff0f84;
    localparam logic [31:0] OFS_P0_FALL_A   = 32'hffff0f88;
    localparam logic [31:0] OFS_P0_FALL_B   = 32'hffff0f8c;
    localparam logic [31:0] OFS_P0_LENGTH   = 32'hffff0f90;
    localparam logic [31:0] OFS_P1_RISE_C   = 32'hffff0f94;
    localparam logic [31:0] OFS_P1_FALL_C   = 32'hffff0f98;
    localparam logic [31:0] OFS_P1_FALL_D   = 32'hffff0f9c;
    localparam logic [31:0] OFS_P1_LENGTH   = 32'hffff0fa0;
    localparam logic [31:0] OFS_P2_RISE_E   = 32'hffff0fa4;
    localparam logic [31:0] OFS_P2_FALL_E   = 32'hffff0fa8;
    localparam logic [31:0] OFS_P2_LENGTH   = 32'hffff0fb0;
    localparam logic [31:0] OFS_INT_CLEAR   = 32'hffff0fb8;
    localparam logic [31:0] OFS_STATUS      = 32'hffff0fbc;

    // ************************************************************
    // control field positions and reset values
    // ************************************************************
    localparam int BIT_GLOBAL_EN   = 0;
    localparam int BIT_BRIDGE_MODE = 1;
    localparam int BIT_DIR         = 2;
    localparam int BIT_LOAD        = 3;
    localparam int BIT_HS_FORCE    = 4;
    localparam int BIT_INVERT_ALL  = 5;
    localparam int BIT_PRESC_LO    = 6;
    localparam int BIT_BRIDGE_EN   = 9;
    localparam int BIT_TRIP_EN     = 10;
    localparam int BIT_INV_B       = 11;
    localparam int BIT_INV_D       = 12;
    localparam int BIT_SYNC_EN     = 14;
    localparam logic [15:0] CONTROL_RESET = 16'h0012;
    localparam logic [15:0] CONTROL_MASK  = 16'h5fff;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] TIMER_ONE     = 16'h0001;
    localparam logic [7:0]  PRESC_RESET   = 8'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] fall2;
        logic [15:0] length;
    } hbpwm_pair_s;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
        logic e;
    } hbpwm_out_s;

endpackage

`default_nettype wire

//--- sim/hbpwm_bridge_model.sv
// hbpwm_bridge_model: far-side switch stage, trip and sync sources
// assumes bench commands the fault level and sync pulsing
`timescale 1ns/100ps
`default_nettype none
module hbpwm_bridge_model (
    // clock
    input  wire logic clk,
    // bench commands
    input  wire logic fault,
    input  wire logic sync_run,
    // pins toward the block
    output logic      trip_n = 1'b1,
    output logic      sync_n = 1'b1
);
    // ****************************
    // pin drivers
    // ****************************
    logic [2:0] cnt = 3'h0;
    // trip pin low while the switches report a fault
    always @(posedge clk) begin
        trip_n <= !fault;
    end
    // sync low one cycle in six while running
    always @(posedge clk) begin
        cnt    <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
        sync_n <= !(sync_run && cnt == 3'h0);
    end
endmodule
`default_nettype wire

//--- sim/test_hbridge_pwm_compare_unit.sv
// test_hbridge_pwm_compare_unit: self-checking bench of hbpwm_top
// assumes the far-side model in hbpwm_bridge_model
`timescale 1ns/100ps
`default_nettype none
module test_hbridge_pwm_compare_unit
    import hbpwm_pkg::*;
;
    logic        clk      = 1'b0;
    logic        reset    = 1'b1;
    logic [31:0] addr     = 32'h0;
    logic [31:0] wdata    = 32'h0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic        fault    = 1'b0;
    logic        sync_run = 1'b0;
    logic [31:0] rdata;
    logic        trip_n;
    logic        sync_n;
    hbpwm_out_s  pwm_out;
    logic        pin_pwm_select;
    logic        pwm_irq;
    int          n_fail   = 0;
    int          compares = 0;
    logic [15:0] hc [5];
    logic [15:0] re;
    localparam logic [31:0] RA [11] = '{OFS_P0_RISE_A, OFS_P0_FALL_A,
        OFS_P0_FALL_B, OFS_P0_LENGTH, OFS_P1_RISE_C, OFS_P1_FALL_C,
        OFS_P1_FALL_D, OFS_P1_LENGTH, OFS_P2_RISE_E, OFS_P2_FALL_E,
        OFS_P2_LENGTH};
    localparam logic [15:0] RV [11] = '{16'h2, 16'h6, 16'h3, 16'h9,
        16'h1, 16'h8, 16'h5, 16'h9, 16'h1, 16'h3, 16'h4};
    localparam logic [31:0] CT [6] = '{32'h000a, 32'h001a, 32'h020a,
        32'h020e, 32'h022a, 32'h022e};
    localparam logic [63:0] EX [6] = '{64'h0014_0014_0014_0014,
        64'h0014_0000_0014_0000, 64'h0000_0000_0008_0008,
        64'h0008_0008_0000_0000, 64'h0008_0008_0014_0014,
        64'h0014_0014_0008_0008};

    always #2.5 clk = ~clk;

    hbpwm_top DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .trip_n(trip_n), .sync_n(sync_n),
        .pwm_out(pwm_out), .pin_pwm_select(pin_pwm_select),
        .pwm_irq(pwm_irq));
    hbpwm_bridge_model far_side (.clk(clk), .fault(fault),
        .sync_run(sync_run), .trip_n(trip_n), .sync_n(sync_n));

    // ****************************
    // shared tasks
    // ****************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // high cycles of each output and rises of e over n clocks
    task automatic meas(input int n);
        logic [4:0] v;
        logic       pe;
        pe = 1'b1;
        re = 16'h0;
        for (int i = 0; i < 5; i++) begin
            hc[i] = 16'h0;
        end
        repeat (n) begin
            @(posedge clk);
            #1;
            v = pwm_out;
            for (int i = 0; i < 5; i++) begin
                hc[i] = hc[i] + 16'(v[4 - i]);
            end
            if (v[0] && !pe) begin
                re = re + 16'h1;
            end
            pe = v[0];
        end
    endtask
    task automatic settle(input int n, input logic [31:0] ctl);
        wreg(OFS_CONTROL, ctl);
        repeat (n) @(posedge clk);
        meas(20);
    endtask
    task automatic edge_a(output int n);
        logic pe;
        logic pr;
        n  = 0;
        pe = pwm_out.a;
        do begin
            @(posedge clk);
            #1;
            n++;
            pr = pe;
            pe = pwm_out.a;
        end while (!(pe === 1'b1 && pr === 1'b0) && n < 6000);
    endtask
    task automatic results();
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************
    // scenarios
    // ****************************
    task automatic t_regs();
        chk(32'(pin_pwm_select), 32'h1);
        chk(32'(pwm_out[4:1]), 32'ha);
        rreg(OFS_CONTROL, 32'h12);
        for (int i = 0; i < 11; i++) begin
            rreg(RA[i], 32'h0);
            wreg(RA[i], 32'hbeef0000 | 32'(RV[i]));
            rreg(RA[i], 32'(RV[i]));
        end
        rreg(OFS_INT_CLEAR, 32'h0);
        rreg(32'hffff0fb4, 32'h0);
    endtask
    task automatic t_wave();
        settle(60, 32'h0009);
        chk(32'(hc[0]), 32'd8);
        chk(32'(hc[1]), 32'd8);
        chk(32'(hc[2]), 32'd14);
        chk(32'(hc[3]), 32'd12);
        chk(32'(hc[4]), 32'd8);
        chk(32'(re), 32'd2);
        settle(4, 32'h020d);
        chk(32'(hc[2]), 32'd14);
        chk(32'(hc[3]), 32'd12);
        settle(4, 32'h1809);
        chk(32'(hc[1]), 32'd12);
        chk(32'(hc[3]), 32'd8);
        settle(4, 32'h0029);
        chk(32'(hc[0]), 32'd12);
        chk(32'(hc[4]), 32'd12);
        settle(4, 32'h0008);
        chk(32'(hc[0]), 32'd0);
        chk(32'(hc[4]), 32'd0);
    endtask
    task automatic t_bridge();
        for (int k = 0; k < 6; k++) begin
            settle(4, CT[k]);
            for (int j = 0; j < 4; j++) begin
                chk(32'(hc[j]), 32'(EX[k][63 - 16 * j -: 16]));
            end
        end
    endtask
    task automatic t_sync();
        sync_run <= 1'b1;
        settle(20, 32'h4009);
        chk(32'(hc[0]), 32'd20);
        settle(40, 32'h0009);
        chk(32'(hc[0]), 32'd8);
        sync_run <= 1'b0;
    endtask
    task automatic t_trip();
        wreg(OFS_CONTROL, 32'h0409);
        fault <= 1'b1;
        repeat (4) @(posedge clk);
        fault <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(pwm_irq), 32'h1);
        rreg(OFS_CONTROL, 32'h0408);
        wreg(OFS_INT_CLEAR, 32'h1234);
        #1;
        chk(32'(pwm_irq), 32'h0);
        wreg(OFS_CONTROL, 32'h0009);
        fault <= 1'b1;
        repeat (4) @(posedge clk);
        fault <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(pwm_irq), 32'h0);
    endtask
    task automatic t_load();
        wreg(OFS_CONTROL, 32'h0001);
        wreg(OFS_P0_FALL_A, 32'h4);
        settle(60, 32'h0001);
        chk(32'(hc[0]), 32'd8);
        settle(60, 32'h0009);
        chk(32'(hc[0]), 32'd4);
    endtask
    task automatic t_presc();
        int n;
        for (int c = 0; c < 8; c++) begin
            wreg(OFS_CONTROL, 32'h9 | (32'(c) << 6));
            edge_a(n);
            edge_a(n);
            edge_a(n);
            chk(32'(n), 32'd10 << (c + 1));
        end
    endtask
    task automatic t_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(pin_pwm_select), 32'h1);
        chk(32'(pwm_out[4:1]), 32'ha);
        rreg(OFS_CONTROL, 32'h12);
        rreg(OFS_P2_LENGTH, 32'h0);
    endtask

    initial begin
        #400000;
        n_fail++;
        $display("Error at %0t ns: watchdog expired", $time);
        results();
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_regs();
        t_wave();
        t_bridge();
        t_sync();
        t_trip();
        t_load();
        t_presc();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
